// ---- rtl/low_side_driver_defs.svh ----
// constants for the low-side driver control block: offsets, fields, resets
// assumes an apb slave with 32-bit data, registers byte-wide in the low bits
`ifndef LOW_SIDE_DRIVER_DEFS_SVH
`define LOW_SIDE_DRIVER_DEFS_SVH

// ==========================================================================
// register indices (printed offsets are not word multiples: byte = 4 * idx)
// ==========================================================================
`define LSD_IDX_DATA        3'h0
`define LSD_IDX_CONFIG      3'h1
`define LSD_IDX_RSVD_A      3'h2
`define LSD_IDX_RSVD_B      3'h3
`define LSD_IDX_RSVD_C      3'h4
`define LSD_IDX_OPEN_LOAD   3'h5
`define LSD_IDX_IRQ_ENABLE  3'h6
`define LSD_IDX_IRQ_FLAGS   3'h7
`define LSD_ADDR_W          12
`define LSD_NUM_REGS        8

// ==========================================================================
// field positions
// ==========================================================================
`define LSD_NUM_DRV         2
`define LSD_CFG_EN_LSB      0
`define LSD_CFG_OLE_LSB     2
`define LSD_IE_OC_BIT       7

// ==========================================================================
// reset values
// ==========================================================================
`define LSD_DATA_RST        2'h0
`define LSD_EN_RST          2'h0
`define LSD_OLE_RST         2'h0
`define LSD_IE_RST          1'h0
`define LSD_FLAG_RST        2'h0

// ==========================================================================
// timing
// ==========================================================================
`define LSD_CLK_NS          20
`define LSD_SETTLE_NS       20000
`define LSD_SETTLE_CYC      ((`LSD_SETTLE_NS + `LSD_CLK_NS - 1) / `LSD_CLK_NS)

`endif

// ---- rtl/low_side_driver_pkg.sv ----
// types for the low-side driver control block
// assumes low_side_driver_defs.svh is included by users of the constants
package low_side_driver_pkg;

    // ======================================================================
    // per-driver power state, gray coded along off -> settling -> ready
    // ======================================================================
    typedef enum logic [1:0] {
        DRV_OFF    = 2'h0,
        DRV_SETTLE = 2'h1,
        DRV_READY  = 2'h3,
        DRV_STOP   = 2'h2
    } drv_state_e;

endpackage

// ---- rtl/low_side_sync2.sv ----
// two-flop synchroniser for a bus of asynchronous levels
// assumes pclk domain, asynchronous active-low reset
`timescale 1ns/10ps
module low_side_sync2 #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    // ======================================================================
    // state
    // ======================================================================
    typedef struct packed {
        logic [W-1:0] meta;   // first stage, read by second only
        logic [W-1:0] sync;   // second stage
    } sync_s;

    sync_s state_reg;
    sync_s state_next;

    // shift the level one stage per edge
    always_comb begin
        state_next      = state_reg;
        state_next.meta = async_in;
        state_next.sync = state_reg.meta;
    end

    // register both stages
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign sync_out = state_reg.sync;

endmodule

// ---- rtl/low_side_drv_chan.sv ----
// one driver channel: enable settling, stop shutdown, gate and mux
// assumes synchronised inputs in the pclk domain
`timescale 1ns/10ps
`include "low_side_driver_defs.svh"
module low_side_drv_chan #(
    parameter int SETTLE_CYC = `LSD_SETTLE_CYC
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic enable,       // driver_enable_bit
    input  wire logic stop_mode,    // low-power stop request
    input  wire logic drive_bit,    // stored data bit
    input  wire logic route_sel,    // 1: routing picked the data bit
    input  wire logic route_src,    // timer or pwm level
    input  wire logic oc_flag,      // over-current flag held
    output logic      bias_on,      // bias of the output stage
    output logic      switch_on,    // switch command
    output logic      settled,      // enable settle time elapsed
    output logic      read_bit      // value seen by a data read
);

    // ======================================================================
    // state
    // ======================================================================
    localparam int CW = $clog2(SETTLE_CYC + 1);

    typedef struct packed {
        low_side_driver_pkg::drv_state_e st;   // power state
        logic [CW-1:0]                   cnt;  // settle counter
        logic                            bias; // registered bias
        logic                            sw;   // registered switch
        logic                            rdy;  // registered settled flag
    } chan_s;

    chan_s state_reg;
    chan_s state_next;
    logic  src_level;   // selected control source level

    // source selection and power sequencing
    always_comb begin
        state_next = state_reg;
        src_level  = route_sel ? drive_bit : route_src;
        case (state_reg.st)
            low_side_driver_pkg::DRV_OFF: begin
                state_next.cnt = '0;
                if (enable && !stop_mode) begin
                    state_next.st = low_side_driver_pkg::DRV_SETTLE;
                end
            end
            low_side_driver_pkg::DRV_SETTLE: begin
                state_next.cnt = state_reg.cnt + CW'(1);
                if (stop_mode) begin
                    state_next.st = low_side_driver_pkg::DRV_STOP;
                end else if (!enable) begin
                    state_next.st = low_side_driver_pkg::DRV_OFF;
                end else if (state_reg.cnt >= CW'(SETTLE_CYC - 1)) begin
                    state_next.st = low_side_driver_pkg::DRV_READY;
                end
            end
            low_side_driver_pkg::DRV_READY: begin
                if (stop_mode) begin
                    state_next.st = low_side_driver_pkg::DRV_STOP;
                end else if (!enable) begin
                    state_next.st = low_side_driver_pkg::DRV_OFF;
                end
            end
            low_side_driver_pkg::DRV_STOP: begin
                // re-enable after stop through a fresh settle
                state_next.cnt = '0;
                if (!stop_mode) begin
                    state_next.st = low_side_driver_pkg::DRV_OFF;
                end
            end
            default: begin
                state_next.st = low_side_driver_pkg::DRV_OFF;
            end
        endcase
        // bias follows enable unless stopped
        state_next.bias = enable && !stop_mode;
        // 1 turns on, 0 off; held off while disabled, stopped or faulted
        state_next.sw   = enable && !stop_mode && !oc_flag && src_level;
        // settled flag kept in a flop so the top output needs no decode
        state_next.rdy  = (state_next.st == low_side_driver_pkg::DRV_READY);
    end

    // register state; reset leaves everything off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '{st: low_side_driver_pkg::DRV_OFF, cnt: '0,
                           bias: 1'b0, sw: 1'b0, rdy: 1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign bias_on   = state_reg.bias;
    assign switch_on = state_reg.sw;
    assign settled   = state_reg.rdy;
    // read shows stored bit or selected source
    assign read_bit  = enable ? src_level : drive_bit;

endmodule

// ---- rtl/low_side_driver_ctrl.sv ----
// register bank and control for two low-side relay drivers, apb slave
// assumes pclk 50 MHz; analog stage, fault and open-load sensors outside
//
// Function
// - after reset both drivers disabled and off
// - eight registers decoded at base plus offset
// - data register readable and writable anytime
// - data bit drives only when routing selects
// - enable low: read returns stored bit
// - enable high: read returns selected source
// - entering stop clears both data bits
// - data bit 1 turns on, 0 off
// - enable bit controls driver bias
// - over-current flags clear by writing one
// - stop shuts drivers; re-enabled after stop
//
// Register access over APB was left to the implementer.
`timescale 1ns/10ps
`include "low_side_driver_defs.svh"
module low_side_driver_ctrl (
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // system and routing
    input  wire logic        stop_mode,
    input  wire logic [1:0]  route_sel,
    input  wire logic [1:0]  route_src,
    // sensors from the analog stage
    input  wire logic [1:0]  overcurrent_in,
    input  wire logic [1:0]  open_load_in,
    // outputs to the analog stage
    output logic             switch_out_zero,
    output logic             switch_out_one,
    output logic      [1:0]  bias_on,
    output logic      [1:0]  open_load_detect_on,
    output logic      [1:0]  settled,
    output logic             fault_irq
);

    // ======================================================================
    // state
    // ======================================================================
    typedef struct packed {
        logic [1:0]  drive_bit;        // driver_data
        logic [1:0]  enable;           // driver_config enable bits
        logic [1:0]  ole;              // driver_config open-load enables
        logic        oc_ie;            // fault_irq_enable bit
        logic [1:0]  oc_flag;          // fault_irq_flags
        logic        stop_prev;        // stop level last cycle
        logic        oc_prev_0;        // over-current edge tracking
        logic        oc_prev_1;
        logic [31:0] rdata;            // read data register
        logic        ready;            // access phase answer
        logic        irq;              // interrupt line
        logic [1:0]  ole_on;           // open-load detect outputs
    } bank_s;

    bank_s state_reg;
    bank_s state_next;

    // ======================================================================
    // input synchronisation (analog-side pins, timer / pwm sources and stop request)
    // ======================================================================
    logic [6:0] async_bus;   // raw pin levels
    logic [6:0] sync_bus;    // synchronised levels
    logic [1:0] oc_s;        // over-current, synchronised
    logic [1:0] ol_s;        // open-load status, synchronised
    logic [1:0] rsrc_s;      // timer / pwm source, synchronised
    logic       stop_s;      // stop request, synchronised

    assign async_bus = {stop_mode, route_src, open_load_in, overcurrent_in};

    low_side_sync2 #(.W(7)) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (async_bus),
        .sync_out (sync_bus)
    );

    assign oc_s   = sync_bus[1:0];
    assign ol_s   = sync_bus[3:2];
    assign rsrc_s = sync_bus[5:4];
    assign stop_s = sync_bus[6];

    // ======================================================================
    // driver channels
    // ======================================================================
    logic [1:0] sw_on;      // switch commands
    logic [1:0] rd_bit;     // data read view

    genvar gi;
    generate
        for (gi = 0; gi < `LSD_NUM_DRV; gi++) begin : g_chan
            low_side_drv_chan u_chan (
                .pclk      (pclk),
                .presetn   (presetn),
                .enable    (state_reg.enable[gi]),
                .stop_mode (stop_s),
                .drive_bit (state_reg.drive_bit[gi]),
                .route_sel (route_sel[gi]),
                .route_src (rsrc_s[gi]),
                .oc_flag   (state_reg.oc_flag[gi]),
                .bias_on   (bias_on[gi]),
                .switch_on (sw_on[gi]),
                .settled   (settled[gi]),
                .read_bit  (rd_bit[gi])
            );
        end
    endgenerate

    // ======================================================================
    // apb decode
    // ======================================================================
    logic       acc;        // access phase, first cycle
    logic       wr_acc;     // write takes effect
    logic       rd_setup;   // read setup cycle, prepare data
    logic       in_map;     // address inside eight words
    logic [2:0] idx;        // register index
    logic       lane0;      // byte lane holding register data
    logic [7:0] wbyte;      // written byte

    assign acc      = psel && penable && state_reg.ready;
    assign in_map   = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'h0);
    assign idx      = paddr[4:2];
    assign lane0    = pstrb[0];
    assign wbyte    = pwdata[7:0];
    assign wr_acc   = acc && pwrite && in_map && lane0;
    assign rd_setup = psel && !penable && !pwrite;

    // register updates, read mux and hardware events
    always_comb begin
        state_next            = state_reg;
        state_next.stop_prev  = stop_s;
        state_next.oc_prev_0  = oc_s[0];
        state_next.oc_prev_1  = oc_s[1];
        // no wait cycle: ready rises in the first access cycle
        state_next.ready      = psel && !state_reg.ready;

        // software writes, no mode restriction on data register
        if (wr_acc) begin
            case (idx)
                `LSD_IDX_DATA: begin
                    state_next.drive_bit = wbyte[1:0];
                end
                `LSD_IDX_CONFIG: begin
                    state_next.enable = wbyte[`LSD_CFG_EN_LSB +: 2];
                    state_next.ole    = wbyte[`LSD_CFG_OLE_LSB +: 2];
                end
                `LSD_IDX_IRQ_ENABLE: begin
                    state_next.oc_ie = wbyte[`LSD_IE_OC_BIT];
                end
                `LSD_IDX_IRQ_FLAGS: begin
                    state_next.oc_flag = state_reg.oc_flag & ~wbyte[1:0];
                end
                default: begin
                    // reserved and read-only: writes ignored
                end
            endcase
        end

        // entering stop clears data bits, wins over a write
        if (stop_s && !state_reg.stop_prev) begin
            state_next.drive_bit = `LSD_DATA_RST;
        end

        // over-current rising edge sets flag; set wins over clear
        if (oc_s[0] && !state_reg.oc_prev_0) begin
            state_next.oc_flag[0] = 1'b1;
        end
        if (oc_s[1] && !state_reg.oc_prev_1) begin
            state_next.oc_flag[1] = 1'b1;
        end

        // read data prepared in the setup cycle
        if (rd_setup) begin
            state_next.rdata = 32'h0000_0000;
            if (in_map) begin
                case (idx)
                    `LSD_IDX_DATA: begin
                        state_next.rdata[1:0] = rd_bit;
                    end
                    `LSD_IDX_CONFIG: begin
                        state_next.rdata[3:0] = {state_reg.ole, state_reg.enable};
                    end
                    `LSD_IDX_OPEN_LOAD: begin
                        state_next.rdata[1:0] = ol_s & state_reg.ole;
                    end
                    `LSD_IDX_IRQ_ENABLE: begin
                        state_next.rdata[`LSD_IE_OC_BIT] = state_reg.oc_ie;
                    end
                    `LSD_IDX_IRQ_FLAGS: begin
                        state_next.rdata[1:0] = state_reg.oc_flag;
                    end
                    default: begin
                        state_next.rdata = 32'h0000_0000;
                    end
                endcase
            end
        end

        // interrupt and open-load detect enable outputs
        state_next.irq    = state_reg.oc_ie && (|state_next.oc_flag) && !stop_s;
        state_next.ole_on = state_reg.ole & state_reg.enable & ~sw_on;
    end

    // register the whole bank
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '{drive_bit: `LSD_DATA_RST, enable: `LSD_EN_RST,
                           ole: `LSD_OLE_RST, oc_ie: `LSD_IE_RST,
                           oc_flag: `LSD_FLAG_RST, stop_prev: 1'b0,
                           oc_prev_0: 1'b0, oc_prev_1: 1'b0,
                           rdata: 32'h0000_0000, ready: 1'b0, irq: 1'b0,
                           ole_on: 2'h0};
        end else begin
            state_reg <= state_next;
        end
    end

    // ======================================================================
    // outputs, all from flip-flops except pslverr, tied low
    // ======================================================================
    assign prdata              = state_reg.rdata;
    assign pready              = state_reg.ready;
    assign pslverr             = 1'b0;
    assign switch_out_zero     = sw_on[0];
    assign switch_out_one      = sw_on[1];
    assign open_load_detect_on = state_reg.ole_on;
    assign fault_irq           = state_reg.irq;

endmodule

// ---- test/low_side_driver_ctrl_checker.sv ----
// checker for the low-side driver register bank, sees top ports only
// assumes one pclk domain and presetn asynchronous active low
`timescale 1ns/10ps
module low_side_driver_ctrl_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        stop_mode,
    input wire logic        switch_out_zero,
    input wire logic        switch_out_one,
    input wire logic [1:0]  bias_on,
    input wire logic [1:0]  settled
);
    // ======================================================================
    // clocking and reset for every property
    // ======================================================================
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // read setup aimed at a reserved or unmapped place
    logic hole_rd;
    assign hole_rd = psel && !penable && !pwrite &&
                     (paddr[4:2] inside {3'h2, 3'h3, 3'h4} || paddr[11:5] != 7'h0);

    // ======================================================================
    // properties
    // ======================================================================
    property p_rst_off;
        $rose(presetn) |-> !switch_out_zero && !switch_out_one && bias_on == 2'h0;
    endproperty
    a_rst_off: assert property (p_rst_off) else $error("outputs active after reset");
    property p_ready_one;
        psel && !penable |=> pready;
    endproperty
    a_ready_one: assert property (p_ready_one) else $error("no ready after setup");
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
    property p_no_err;
        pready |-> !pslverr;
    endproperty
    a_no_err: assert property (p_no_err) else $error("error response");
    property p_hole_read;
        hole_rd |=> prdata == 32'h0;
    endproperty
    a_hole_read: assert property (p_hole_read) else $error("reserved read not zero");
    property p_upper_zero;
        pready |-> prdata[31:8] == 24'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
    property p_stop_off;
        stop_mode [*5] |-> bias_on == 2'h0 && !switch_out_zero && !switch_out_one;
    endproperty
    a_stop_off: assert property (p_stop_off) else $error("driver active in stop");
    property p_bias_switch;
        !bias_on[0] [*3] |-> !switch_out_zero;
    endproperty
    a_bias_switch: assert property (p_bias_switch) else $error("on while disabled");
    property p_settle_start;
        $rose(bias_on[1]) |-> !settled[1];
    endproperty
    a_settle_start: assert property (p_settle_start) else $error("settled too soon");

    // ======================================================================
    // covers
    // ======================================================================
    c_write: cover property (pready && pwrite);
    c_stop: cover property (stop_mode [*5]);
    c_settle: cover property ($rose(settled[0]));
endmodule

bind low_side_driver_ctrl low_side_driver_ctrl_checker low_side_driver_ctrl_checker_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
    .stop_mode, .switch_out_zero, .switch_out_one, .bias_on, .settled
);

// ---- test/low_side_driver_ctrl_tb.sv ----
// directed testbench for the low-side driver register bank over apb
// assumes the checker is bound by its own file; pclk 50 MHz
`timescale 1ns/10ps
module low_side_driver_ctrl_tb;
    logic        pclk, presetn, psel, penable, pwrite, stop_mode, pready, pslverr;
    logic        sw0, sw1, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [1:0]  route_sel, route_src, oc_in, bias, ol_on, settled;
    int          err_total, n_checks;
    localparam logic [11:0] A_DATA = 12'h000, A_CFG = 12'h004, A_IE = 12'h018;
    localparam logic [11:0] A_IF = 12'h01C;

    // ======================================================================
    // design under test
    // ======================================================================
    low_side_driver_ctrl low_side_driver_ctrl_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .stop_mode(stop_mode), .route_sel(route_sel),
        .route_src(route_src), .overcurrent_in(oc_in), .open_load_in(2'h0),
        .switch_out_zero(sw0), .switch_out_one(sw1), .bias_on(bias),
        .open_load_detect_on(ol_on), .settled(settled), .fault_irq(irq)
    );

    // ======================================================================
    // clock, verdict and compare tasks
    // ======================================================================
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic fail(input string m);
        err_total++;
        $display("CHECK FAILED at %0t: %s", $time, m);
    endtask
    // register read data against expectation
    task automatic chk_rd(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) fail($sformatf("read %h expected %h", g, e));
    endtask
    // pin pair against expectation
    task automatic chk_pin(input logic [1:0] g, input logic [1:0] e, input string m);
        n_checks++;
        if (g !== e) fail($sformatf("%s is %b expected %b", m, g, e));
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // ======================================================================
    // apb master: setup, access until ready, one idle cycle
    // ======================================================================
    task automatic bus(input logic [11:0] a, input logic w, input logic [7:0] d,
                       output logic [31:0] q);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) fail("no ready");
        q = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, q);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(a, 1'b0, 8'h00, q);
        chk_rd(q, e);
    endtask

    // ======================================================================
    // watchdog
    // ======================================================================
    initial begin
        tick(20000);
        fail("timeout");
        end_sim();
    end

    // ======================================================================
    // test sequence
    // ======================================================================
    initial begin
        err_total = 0;
        n_checks = 0;
        {presetn, psel, penable, pwrite, stop_mode} = 5'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        {route_sel, route_src, oc_in} = 6'h0;
        tick(5);
        presetn <= 1'b1;
        for (int i = 0; i < 8; i++) rd(12'(i * 4), 32'h0);
        chk_pin({sw1, sw0} | bias, 2'h0, "outputs after reset");
        $display("test done: reset");
        route_sel <= 2'h3;
        wr(A_DATA, 8'hFF);
        rd(A_DATA, 32'h3);
        tick(3);
        chk_pin({sw1, sw0}, 2'h0, "switch while disabled");
        for (int i = 2; i < 5; i++) wr(12'(i * 4), 8'hFF);
        for (int i = 2; i < 5; i++) rd(12'(i * 4), 32'h0);
        wr(A_DATA, 8'h00);
        wr(A_CFG, 8'hFF);
        rd(A_CFG, 32'hF);
        chk_pin(ol_on, 2'h3, "open-load detect on");
        wr(A_IE, 8'h7F);
        rd(A_IE, 32'h0);
        rd(12'h020, 32'h0);
        rd(12'h005, 32'h0);
        wr(A_CFG, 8'h03);
        $display("test done: masks");
        tick(3);
        chk_pin(bias, 2'h3, "bias after enable");
        tick(1005);
        chk_pin(settled, 2'h3, "settled");
        wr(A_DATA, 8'h03);
        tick(2);
        chk_pin({sw1, sw0}, 2'h3, "switch on");
        wr(A_DATA, 8'h01);
        tick(2);
        chk_pin({sw1, sw0}, 2'h1, "switch one off");
        route_sel <= 2'h1;
        route_src <= 2'h2;
        tick(5);
        rd(A_DATA, 32'h3);
        chk_pin({sw1, sw0}, 2'h3, "routed source on");
        route_src <= 2'h0;
        tick(5);
        rd(A_DATA, 32'h1);
        chk_pin({sw1, sw0}, 2'h1, "routed source off");
        route_sel <= 2'h3;
        $display("test done: routing");
        oc_in <= 2'h1;
        tick(5);
        chk_pin({sw1, sw0}, 2'h0, "switch under fault");
        wr(A_IF, 8'h00);
        rd(A_IF, 32'h1);
        wr(A_IE, 8'h80);
        tick(2);
        chk_pin({1'b0, irq}, 2'h1, "fault irq");
        oc_in <= 2'h0;
        wr(A_IF, 8'h01);
        rd(A_IF, 32'h0);
        tick(2);
        chk_pin({irq, sw0}, 2'h1, "fault cleared");
        $display("test done: fault");
        route_sel <= 2'h0;
        wr(A_DATA, 8'h03);
        chk_pin({sw1, sw0}, 2'h0, "off before stop");
        stop_mode <= 1'b1;
        tick(6);
        chk_pin(bias | {sw1, sw0}, 2'h0, "stop shutdown");
        stop_mode <= 1'b0;
        tick(6);
        route_sel <= 2'h3;
        rd(A_DATA, 32'h0);
        rd(A_CFG, 32'h3);
        chk_pin(bias, 2'h3, "bias after stop");
        chk_pin({sw1, sw0}, 2'h0, "stays off after stop");
        wr(A_CFG, 8'h00);
        tick(2);
        chk_pin(bias, 2'h0, "bias after disable");
        $display("test done: stop");
        end_sim();
    end
endmodule
